// [inc/twrap_pkg.sv]
// What this block does
// - Serial port handles reads and writes at bit rates up to 400 kbit/s.
// - Each further written byte lands at the next register; pointer steps.
// - Data line changes only while serial clock is low.
// - Falling data with clock high is a start; parsing restarts at address.
// - Rising data with clock high is a stop; frame ends, bus released.
// - Slave pulls data low through the ninth clock of every byte written to its own address.
package twrap_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int PTR_W = 8;
    localparam int NUM_REGS = 256;
    localparam logic [ADDR_W-1:0] OWN_ADDR_RST = 7'h69;
    localparam logic [PTR_W-1:0] PTR_RST = 8'h00;
    localparam logic [DATA_W-1:0] REG_RST = 8'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_RST = 4'h0;
    localparam int MAX_RATE_KBPS = 400;
    localparam int CLK_MHZ = 25;
    // Sample clocks per link bit at top rate; must stay above 8
    localparam int CYC_PER_BIT = (CLK_MHZ * 1000) / MAX_RATE_KBPS;

    typedef enum logic [2:0] {
        TW_IDLE = 3'b000,
        TW_ADDR = 3'b001,
        TW_PTR = 3'b011,
        TW_WDATA = 3'b010,
        TW_RDATA = 3'b110,
        TW_RACK = 3'b111,
        TW_SKIP = 3'b101
    } twrap_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } twrap_pins_t;

    typedef struct packed {
        logic we;
        logic [PTR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } twrap_wr_t;

    typedef struct packed {
        twrap_pins_t s1;
        twrap_pins_t s2;
        twrap_pins_t prev;
        twrap_state_t st;
        logic [3:0] bitn;
        logic [DATA_W-1:0] shreg;
        logic ack_phase;
        logic rd_mode;
        logic [PTR_W-1:0] ptr;
        logic sda_oe;
        twrap_wr_t wr;
        logic busy;
    } twrap_state_s_t;

endpackage

// [core/twrap_port.sv]
`timescale 1ns/1ps
module twrap_port import twrap_pkg::*; (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic [ADDR_W-1:0] TARGET_SELECT_CODE_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    output logic WR_EN_OUT,
    output logic [PTR_W-1:0] WR_ADDR_OUT,
    output logic [DATA_W-1:0] WR_DATA_OUT,
    output logic BUSY_OUT
);

    // ****************************************
    // Register array and state
    // ****************************************
    logic [DATA_W-1:0] regs_q [NUM_REGS];
    twrap_state_s_t s_q;
    twrap_state_s_t s_d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [DATA_W-1:0] rd_next;

    function automatic logic addr_hit(input logic [DATA_W-1:0] b,
                                      input logic [ADDR_W-1:0] own);
        addr_hit = (b[DATA_W-1:1] == own);
    endfunction

    // Frame states that still follow the bus
    function automatic logic frame_live(input twrap_state_t st);
        frame_live = (st != TW_IDLE) && (st != TW_SKIP);
    endfunction

    // Receive states shift the line in; send states hold their byte
    function automatic logic rx_shift(input twrap_state_t st,
                                      input logic rd);
        rx_shift = !rd || (st == TW_ADDR) || (st == TW_PTR);
    endfunction

    // Open drain: a zero bit pulls, a one bit releases
    function automatic logic pull_for(input logic b);
        pull_for = ~b;
    endfunction

    // Refill with ones so a stale bit can never pull the line
    function automatic logic [DATA_W-1:0] tx_rest(
        input logic [DATA_W-1:0] b);
        tx_rest = {b[DATA_W-2:0], 1'b1};
    endfunction

    // ****************************************
    // Edge and condition detect
    // ****************************************
    // Edges compare the second sync stage with the compare stage
    assign scl_rise = s_q.s2.scl & ~s_q.prev.scl;
    assign scl_fall = ~s_q.s2.scl & s_q.prev.scl;

    // Conditions need the clock high on both samples
    assign start_seen = s_q.s2.scl & s_q.prev.scl
                        & s_q.prev.sda & ~s_q.s2.sda;
    assign stop_seen = s_q.s2.scl & s_q.prev.scl
                       & ~s_q.prev.sda & s_q.s2.sda;

    // Read source is the byte the pointer names
    assign rd_next = regs_q[s_q.ptr];

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        // Two flops per pin, then one compare stage
        s_d.s1.scl = SCL_IN;
        s_d.s1.sda = SDA_IN;
        s_d.s2 = s_q.s1;
        s_d.prev = s_q.s2;
        s_d.wr.we = 1'b0;

        // ****************************************
        // Frame parsing
        // ****************************************
        if (start_seen) begin
            s_d.st = TW_ADDR;
            s_d.bitn = BIT_RST;
            // The clock fall after a start carries no bit; soak it up
            s_d.ack_phase = 1'b1;
            s_d.sda_oe = 1'b0;
            s_d.busy = 1'b1;
        end else if (stop_seen) begin
            // Ends the frame even in mid-byte
            s_d.st = TW_IDLE;
            s_d.sda_oe = 1'b0;
            s_d.busy = 1'b0;
        end else if (frame_live(s_q.st)) begin
            // Sampling on rise, driving on fall keeps SDA still while high
            if (scl_rise && !s_q.ack_phase) begin
                if (rx_shift(s_q.st, s_q.rd_mode)) begin
                    s_d.shreg = {s_q.shreg[DATA_W-2:0], s_q.s2.sda};
                end
            end

            if (scl_rise && s_q.ack_phase && s_q.st == TW_RACK) begin
                // Master NACK ends the read burst
                if (s_q.s2.sda) begin
                    s_d.st = TW_SKIP;
                end
            end

            if (scl_fall) begin
                if (s_q.ack_phase) begin
                    // Ninth bit over: let go of the line, rearm the count
                    s_d.ack_phase = 1'b0;
                    s_d.bitn = BIT_RST;
                    s_d.sda_oe = 1'b0;
                    if (s_q.st == TW_RACK || (s_q.st == TW_RDATA)) begin
                        s_d.st = TW_RDATA;
                        s_d.sda_oe = pull_for(rd_next[DATA_W-1]);
                        s_d.shreg = tx_rest(rd_next);
                        // Pointer wraps past the last register
                        s_d.ptr = s_q.ptr + 8'h01;
                    end
                end else if (s_q.bitn == BIT_LAST) begin
                    s_d.ack_phase = 1'b1;
                    s_d.sda_oe = 1'b0;
                    case (s_q.st)
                        TW_ADDR: begin
                            // Direction bit picks the path
                            if (addr_hit(s_q.shreg,
                                         TARGET_SELECT_CODE_IN)) begin
                                s_d.sda_oe = 1'b1;
                                s_d.rd_mode = s_q.shreg[0];
                                s_d.st = s_q.shreg[0] ? TW_RDATA : TW_PTR;
                            end else begin
                                // Stay off the line until the next start
                                s_d.st = TW_SKIP;
                                s_d.ack_phase = 1'b0;
                            end
                        end
                        TW_PTR: begin
                            // Pointer byte sets where writes land
                            s_d.ptr = s_q.shreg;
                            s_d.sda_oe = 1'b1;
                            s_d.st = TW_WDATA;
                        end
                        TW_WDATA: begin
                            // Store at the pointer, then step it
                            s_d.wr.we = 1'b1;
                            s_d.wr.addr = s_q.ptr;
                            s_d.wr.data = s_q.shreg;
                            s_d.ptr = s_q.ptr + 8'h01;
                            s_d.sda_oe = 1'b1;
                        end
                        TW_RDATA: begin
                            // Master owns the ninth bit on reads
                            s_d.st = TW_RACK;
                        end
                        default: begin
                            s_d.st = TW_SKIP;
                        end
                    endcase
                end else begin
                    s_d.bitn = s_q.bitn + 4'h1;
                    // Mid-byte fall: the next send bit goes out
                    if (s_q.st == TW_RDATA) begin
                        s_d.sda_oe = pull_for(s_q.shreg[DATA_W-1]);
                        s_d.shreg = tx_rest(s_q.shreg);
                    end
                end
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            // Idle bus levels, so no false edge follows reset
            s_q <= '{
                s1: '{scl: 1'b1, sda: 1'b1},
                s2: '{scl: 1'b1, sda: 1'b1},
                prev: '{scl: 1'b1, sda: 1'b1},
                st: TW_IDLE,
                bitn: BIT_RST,
                shreg: REG_RST,
                ack_phase: 1'b0,
                rd_mode: 1'b0,
                ptr: PTR_RST,
                sda_oe: 1'b0,
                wr: '{we: 1'b0, addr: PTR_RST, data: REG_RST},
                busy: 1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Register array
    // ****************************************
    // Array kept out of reset so it can map to RAM
    always_ff @(posedge CLK_IN) begin
        if (s_q.wr.we) begin
            regs_q[s_q.wr.addr] <= s_q.wr.data;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Open drain: only the enable moves, the value stays low
    assign SDA_OUT = 1'b0;
    assign SDA_OE_OUT = s_q.sda_oe;
    assign WR_EN_OUT = s_q.wr.we;
    assign WR_ADDR_OUT = s_q.wr.addr;
    assign WR_DATA_OUT = s_q.wr.data;
    assign BUSY_OUT = s_q.busy;

endmodule

// [verification/twrap_port_properties.sv]
`timescale 1ns/1ps
// ****
// Port checks
// ****
module twrap_props import twrap_pkg::*; (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic [ADDR_W-1:0] TARGET_SELECT_CODE_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_OUT,
    input wire logic WR_EN_OUT,
    input wire logic [PTR_W-1:0] WR_ADDR_OUT,
    input wire logic [DATA_W-1:0] WR_DATA_OUT,
    input wire logic BUSY_OUT
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);
    one_shot_a: assert property (WR_EN_OUT |=> !WR_EN_OUT)
        else $error("write strobe longer than one cycle");
    write_in_frame_a: assert property (WR_EN_OUT |-> BUSY_OUT)
        else $error("write strobe outside a frame");
    // Sync delay: only a clock high for 3 samples is settled
    hold_high_a: assert property (SCL_IN && $past(SCL_IN, 3) |->
        $stable(SDA_OE_OUT)) else $error("data moved while clock high");
    start_seen_a: assert property ($fell(SDA_IN) && SCL_IN &&
        $past(SCL_IN) |-> ##[1:5] BUSY_OUT) else $error("start missed");
    stop_seen_a: assert property ($rose(SDA_IN) && SCL_IN &&
        $past(SCL_IN) |-> ##[1:5] (!BUSY_OUT && !SDA_OE_OUT))
        else $error("stop did not end frame");
    idle_quiet_a: assert property (!BUSY_OUT |->
        !SDA_OE_OUT && !WR_EN_OUT) else $error("activity while idle");
    ack_hold_a: assert property ($rose(SDA_OE_OUT) |=>
        SDA_OE_OUT [*5]) else $error("data pull dropped early");
    open_drain_a: assert property (SDA_OUT == 1'b0)
        else $error("data output value not low");
endmodule

bind twrap_port twrap_props twrap_props_inst (.CLK_IN(CLK_IN),
    .SYS_RST_IN(SYS_RST_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .TARGET_SELECT_CODE_IN(TARGET_SELECT_CODE_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE_OUT(SDA_OE_OUT), .WR_EN_OUT(WR_EN_OUT),
    .WR_ADDR_OUT(WR_ADDR_OUT), .WR_DATA_OUT(WR_DATA_OUT),
    .BUSY_OUT(BUSY_OUT));

// [verification/twrap_master.sv]
`timescale 1ns/1ps
// ****
// Bus master model
// ****
module twrap_master (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // 320 ns bit, beyond the top rate: only 8 samples a bit
    task automatic bit_x(input logic b, output logic r);
        scl = 1'b0;
        #80 sda_low = !b; // Data moves only with clock low
        #80 scl = 1'b1;
        #150 r = sda; // Late sample: device answer lags the fall
        #10;
    endtask
    // Also a repeated start; parsing restarts at address
    task automatic start();
        scl = 1'b0;
        #80 sda_low = 1'b0;
        #80 scl = 1'b1;
        #80 sda_low = 1'b1;
        #80;
    endtask
    task automatic stop();
        scl = 1'b0;
        #80 sda_low = 1'b1;
        #80 scl = 1'b1;
        #80 sda_low = 1'b0;
        #80;
    endtask
    // MSB first, ninth bit is the acknowledge
    task automatic xfer(input logic [7:0] d, input logic ak,
        output logic [7:0] q, output logic r);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(ak, r);
    endtask
endmodule

// [verification/twrap_port_tb.sv]
`timescale 1ns/1ps
// ****
// Bench
// ****
module twrap_port_tb;
    logic clk = 0, rst = 1, scl, low, oe, wen, busy, a;
    logic [7:0] wa, wd, q;
    logic [7:0] qa[$], qd[$];
    int n_errors = 0, total_checks = 0, cyc = 0;
    wire sda = !(low | oe);
    always #20 clk = !clk;
    twrap_port twrap_port_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .SCL_IN(scl),
        .SDA_IN(sda), .TARGET_SELECT_CODE_IN(7'h69), .SDA_OUT(),
        .SDA_OE_OUT(oe), .WR_EN_OUT(wen), .WR_ADDR_OUT(wa),
        .WR_DATA_OUT(wd), .BUSY_OUT(busy));
    twrap_master twrap_master_inst (.scl(scl), .sda_low(low), .sda(sda));
    task automatic wrap_up();
        if (n_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic [7:0] d, input logic e);
        twrap_master_inst.xfer(d, 1'b1, q, a);
        chk({7'h0, a}, {7'h0, e});
    endtask
    always @(posedge clk) begin
        cyc++;
        if (wen === 1'b1) begin
            qa.push_back(wa);
            qd.push_back(wd);
        end
        if (cyc == 3000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic t_write();
        twrap_master_inst.start();
        wb(8'hd2, 0);
        wb(8'hfe, 0);
        for (int i = 0; i < 3; i++) wb(8'h5a + 8'(i * 105), 0);
        twrap_master_inst.stop();
        repeat (6) @(posedge clk);
        #1;
        chk({7'h0, busy}, 8'h00);
        for (int i = 0; i < 3; i++) begin
            chk(qa[i], 8'hfe + 8'(i)); // Pointer steps and wraps
            chk(qd[i], 8'h5a + 8'(i * 105));
        end
    endtask
    task automatic t_read();
        twrap_master_inst.start();
        wb(8'hd2, 0);
        wb(8'hfe, 0);
        twrap_master_inst.start();
        wb(8'hd3, 0);
        twrap_master_inst.xfer(8'hff, 1'b0, q, a);
        chk(q, 8'h5a);
        twrap_master_inst.xfer(8'hff, 1'b1, q, a);
        chk(q, 8'hc3);
        twrap_master_inst.stop();
        chk(8'(qa.size()), 8'h03);
    endtask
    task automatic t_other();
        twrap_master_inst.start();
        wb(8'h24, 1);
        wb(8'h00, 1);
        twrap_master_inst.stop();
        chk(8'(qa.size()), 8'h03);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 0;
        repeat (3) @(posedge clk);
        #1;
        t_write();
        t_read();
        t_other();
        wrap_up();
    end
endmodule
